// file: stcr_pkg.sv
// Package for the synthesizer tuning configuration register bank
package stcr_pkg;

  // ---------------------------------------------------------------
  // Register offsets (register index; byte address is index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] STCR_IDX_PUMP = 8'h2a;
  localparam logic [7:0] STCR_IDX_CAL = 8'h2e;
  localparam logic [7:0] STCR_IDX_DITHER = 8'h2f;
  localparam int STCR_ADR_LSB = 2;
  localparam int STCR_IDX_W = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] STCR_RST_PUMP = 16'h0210;
  localparam logic [15:0] STCR_RST_CAL = 16'h001a;
  localparam logic [15:0] STCR_RST_DITHER = 16'h0000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STCR_DITHER_LO = 13;
  localparam int STCR_CAL_EN_BIT = 2;
  localparam int STCR_CAL_CORE_LO = 0;
  localparam int STCR_POL_BIT = 5;
  localparam int STCR_IDN_LO = 0;

  // Control register: bit 0 requests a reset of the bank
  localparam logic [7:0] STCR_IDX_CTRL = 8'h00;
  localparam int STCR_CTRL_RST_BIT = 0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    STCR_DITHER_OFF = 2'h0,
    STCR_DITHER_WEAK = 2'h1,
    STCR_DITHER_MEDIUM = 2'h2,
    STCR_DITHER_STRONG = 2'h3
  } stcr_dither_t;

  typedef enum logic [1:0] {
    STCR_LOW_CORE = 2'h0,
    STCR_MIDDLE_CORE = 2'h1,
    STCR_HIGH_CORE = 2'h2,
    STCR_CORE_UNUSED = 2'h3
  } stcr_core_t;

  typedef struct packed {
    stcr_dither_t dither_level;
    logic cal_start_core_enable;
    stcr_core_t cal_start_core_choice;
    logic ext_osc_detector_polarity;
    logic [4:0] ext_osc_pump_down_current;
  } stcr_cfg_t;

endpackage

// file: stcr_regs.sv
// Synthesizer tuning configuration registers behind a Wishbone slave
`timescale 1ns/100ps
// Contract
// - Two-bit dither field, bits 14-13: off, weak, medium, strong.
// - Start-core enable set makes calibration start from the chosen core.
// - Start-core choice 0 low, 1 middle, 2 high; resets to 2.
// - Reset values alone must let the core be chosen automatically.
// - Polarity bit: 0 positive tuning sense, 1 negative.
// - Five-bit down-current, 156.25 uA per code, 0 tri-states the pump.
// - All registers take reset values at power-up or on reset bit.
module stcr_regs
  import stcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output stcr_cfg_t cfg_o,
  output logic cal_start_from_core_o,
  output stcr_core_t cal_start_core_o
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [15:0] pump_q;
  logic [15:0] cal_q;
  logic [15:0] dither_q;
  logic soft_rst_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  stcr_cfg_t cfg_q;
  logic start_q;
  stcr_core_t start_core_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic [STCR_IDX_W-1:0] idx =
    wb_adr_i[STCR_ADR_LSB +: STCR_IDX_W];
  wire logic adr_high_zero =
    (wb_adr_i[31:STCR_ADR_LSB+STCR_IDX_W] == '0) &&
    (wb_adr_i[STCR_ADR_LSB-1:0] == '0);
  wire logic req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  wire logic hit_pump = adr_high_zero && (idx == STCR_IDX_PUMP);
  wire logic hit_cal = adr_high_zero && (idx == STCR_IDX_CAL);
  wire logic hit_dither = adr_high_zero && (idx == STCR_IDX_DITHER);
  wire logic hit_ctrl = adr_high_zero && (idx == STCR_IDX_CTRL);
  wire logic hit_any = hit_pump || hit_cal || hit_dither || hit_ctrl;
  wire logic wr = req && wb_we_i && hit_any;
  wire logic [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] wdat = wb_dat_i[15:0];

  // Reset-request bit takes effect on the next edge
  wire logic ctrl_wr = wr && hit_ctrl && wb_sel_i[0];
  wire logic bank_rst = srst || soft_rst_q;

  wire logic [15:0] pump_d =
    (wr && hit_pump) ? ((pump_q & ~wmask) | (wdat & wmask)) : pump_q;
  wire logic [15:0] cal_d =
    (wr && hit_cal) ? ((cal_q & ~wmask) | (wdat & wmask)) : cal_q;
  wire logic [15:0] dither_d =
    (wr && hit_dither) ? ((dither_q & ~wmask) | (wdat & wmask))
                       : dither_q;

  wire logic [15:0] rsel =
    hit_pump ? pump_q :
    hit_cal ? cal_q :
    hit_dither ? dither_q :
    {15'h0000, soft_rst_q};
  wire logic [31:0] rdata_d = {16'h0000, rsel};

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  stcr_cfg_t cfg_d;
  assign cfg_d.dither_level =
    stcr_dither_t'(dither_q[STCR_DITHER_LO +: 2]);
  assign cfg_d.cal_start_core_enable = cal_q[STCR_CAL_EN_BIT];
  assign cfg_d.cal_start_core_choice =
    stcr_core_t'(cal_q[STCR_CAL_CORE_LO +: 2]);
  assign cfg_d.ext_osc_detector_polarity = pump_q[STCR_POL_BIT];
  assign cfg_d.ext_osc_pump_down_current =
    pump_q[STCR_IDN_LO +: 5];

  // Start option disabled: calibration picks the core itself
  wire logic start_d = cfg_d.cal_start_core_enable;
  wire stcr_core_t start_core_d =
    start_d ? cfg_d.cal_start_core_choice : STCR_HIGH_CORE;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (bank_rst) begin
      pump_q <= STCR_RST_PUMP;
      cal_q <= STCR_RST_CAL;
      dither_q <= STCR_RST_DITHER;
    end else begin
      pump_q <= pump_d;
      cal_q <= cal_d;
      dither_q <= dither_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= ctrl_wr && wdat[STCR_CTRL_RST_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req && hit_any;
      err_q <= req && !hit_any;
      rdata_q <= (req && hit_any && !wb_we_i) ? rdata_d : '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (bank_rst) begin
      cfg_q <= '{STCR_DITHER_OFF, 1'b0, STCR_HIGH_CORE, 1'b0,
                 STCR_RST_PUMP[STCR_IDN_LO +: 5]};
      start_q <= 1'b0;
      start_core_q <= STCR_HIGH_CORE;
    end else begin
      cfg_q <= cfg_d;
      start_q <= start_d;
      start_core_q <= start_core_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;
  assign cfg_o = cfg_q;
  assign cal_start_from_core_o = start_q;
  assign cal_start_core_o = start_core_q;

endmodule // stcr_regs

// file: stcr_regs_chk.sv
// Checker for the tuning configuration register bank
`timescale 1ns/100ps
module stcr_regs_chk
  import stcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire stcr_cfg_t cfg_o,
  input wire logic cal_start_from_core_o,
  input wire stcr_core_t cal_start_core_o
);
  // ------
  // Assertions
  // ------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire reply = wb_ack_o | wb_err_o;
  sequence pulse_s; reply ##1 !reply; endsequence
  reply_cause_a: assert property (
    reply |-> $past(wb_cyc_i & wb_stb_i)) else $error("reply unasked");
  reply_pulse_a: assert property (reply |-> pulse_s)
    else $error("reply too long");
  reply_excl_a: assert property (!(wb_ack_o & wb_err_o))
    else $error("ack with err");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 0)
    else $error("data outside ack");
  dat_upper_a: assert property (wb_dat_o[31:16] == 16'h0)
    else $error("upper data set");
  core_en_a: assert property (
    cal_start_from_core_o == cfg_o.cal_start_core_enable)
    else $error("enable mismatch");
  core_sel_a: assert property (cal_start_from_core_o |->
    cal_start_core_o == cfg_o.cal_start_core_choice) else $error("core");
  core_auto_a: assert property (!cal_start_from_core_o |->
    cal_start_core_o == STCR_HIGH_CORE) else $error("auto core");
  cfg_reset_a: assert property ($fell(srst) |-> cfg_o == 11'h090)
    else $error("cfg reset value");
endmodule // stcr_regs_chk
bind stcr_regs stcr_regs_chk u_chk (.core_clk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cfg_o,
  .cal_start_from_core_o, .cal_start_core_o);

// file: testbench.sv
// Self-checking bench for the tuning configuration register bank
`timescale 1ns/100ps
module testbench
  import stcr_pkg::*;
;
  logic core_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, dat_o;
  logic ack, err, from_core;
  logic [3:0] sel = 4'h3;
  stcr_cfg_t cfg;
  stcr_core_t core;
  int mismatches = 0, checks_done = 0;
  always #10 core_clk = ~core_clk;
  stcr_regs DUT (.core_clk, .srst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .cfg_o(cfg),
    .cal_start_from_core_o(from_core), .cal_start_core_o(core));
  task automatic chk(string nm, logic [31:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic xfer(logic w, logic [31:0] a, d, logic e = 0);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    @(posedge core_clk);
    while (!(ack | err)) @(posedge core_clk);
    rdat = dat_o;
    chk("reply", {e, !e}, {err, ack});
    cyc <= 0; stb <= 0;
  endtask
  task automatic rd_chk(string nm, logic [31:0] a, ex);
    xfer(0, a, 0);
    chk(nm, ex, rdat);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    rd_chk("pump", 8'ha8, 32'h210);
    rd_chk("cal", 8'hb8, 32'h1a);
    rd_chk("dither", 8'hbc, 0);
    chk("core", 2, core);
    chk("cfg", 11'h090, cfg);
  endtask
  task automatic t_dither;
    for (int c = 0; c < 4; c++) begin
      xfer(1, 8'hbc, c << 13);
      rd_chk("dither", 8'hbc, c << 13);
      chk("level", c, cfg.dither_level);
    end
    sel <= 4'h2;
    xfer(1, 8'hbc, 32'h40ff);
    sel <= 4'h3;
    rd_chk("dither_lane", 8'hbc, 32'h4000);
    chk("lane_level", 2, cfg.dither_level);
  endtask
  task automatic t_cal;
    for (int c = 0; c < 3; c++) begin
      xfer(1, 8'hb8, 32'h1c | c);
      rd_chk("cal", 8'hb8, 32'h1c | c);
      chk("start", {1'b1, 2'(c)}, {from_core, core});
    end
    xfer(1, 8'hb8, 32'h18);
    rd_chk("cal", 8'hb8, 32'h18);
    chk("auto", 3'h2, {from_core, core});
  endtask
  task automatic t_pump;
    logic [31:0] v[2] = '{32'h23e, 32'h200};
    foreach (v[i]) begin
      xfer(1, 8'ha8, v[i]);
      rd_chk("pump", 8'ha8, v[i]);
      chk("pol_idn", v[i][5:0], cfg[5:0]);
    end
  endtask
  task automatic t_err;
    xfer(0, 32'h4, 0, 1);
    chk("err_dat", 0, rdat);
    xfer(1, 32'hab, 0, 1);
    rd_chk("pump", 8'ha8, 32'h200);
    xfer(1, 0, 1);
    rd_chk("pump", 8'ha8, 32'h210);
    rd_chk("dither", 8'hbc, 0);
    xfer(1, 8'hb8, 32'h1d);
    rd_chk("cal_pre", 8'hb8, 32'h1d);
    @(posedge core_clk) srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    rd_chk("cal", 8'hb8, 32'h1a);
    chk("core_rst", 3'h2, {from_core, core});
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 0;
    t_reset;
    t_dither;
    t_cal;
    t_pump;
    t_err;
    tally_and_finish;
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
endmodule // testbench
